// ===== design/gosm_defines.svh
`ifndef GOSM_DEFINES_SVH
`define GOSM_DEFINES_SVH

// register index as printed; byte address is four times it
`define GOSM_CTRL_IDX      8'h15
`define GOSM_CTRL_ADDR     8'h54
`define GOSM_CTRL_RESET    8'h00

// field positions inside the control byte
`define GOSM_SEL_HI        7
`define GOSM_SEL_LO        5
`define GOSM_SRC_HI        4
`define GOSM_SRC_LO        2
`define GOSM_VAL_BIT       1
`define GOSM_EN_BIT        0

// input synchroniser depth for pin-side status inputs
`define GOSM_SYNC_STAGES   3

`endif

// ===== design/gosm_pin5.sv
// What this block does
// [R01] source field: 0xx receive port, 100 status, 101 reserved, 11x transmit
// [R02] selection field picks a signal inside the current source group
// [R03] receive source: selections 000..011 forward remote pins 0..3
// [R04] receive source: 100 drives port lock, 101 drives port pass
// [R05] receive source: 110 drives frame valid, 111 drives line valid
// [R06] status source: 000 drives the register level bit
// [R07] status source: 001 drives OR of lock of enabled ports
// [R08] status source: 010 drives AND of lock of enabled ports
// [R09] status source: 011 drives AND of pass of enabled ports
// [R10] status source: 100 drives frame sync; 101..111 drive low
// [R11] source 11x picks transmit port by the low source bit
// [R12] transmit source: 000 AND, 001 OR of assigned ports' pass
// [R13] transmit source: 010 frame in progress, 011 line in progress
// [R14] transmit source: 100 merged multi-port data synchronized
// [R15] transmit source: 101 interrupt; 110 and 111 reserved, low
// [R16] register level bit drives pin when selected and enabled
// [R17] enable bit 1 drives the pin, 0 releases it
// [R18] control register resets to zero; all fields read and write
`timescale 1ns/10ps
`include "gosm_defines.svh"

module gosm_pin5 #(
	parameter int NUM_RX = 4,
	parameter int NUM_TX = 2
) (
	// clock and reset
	input  wire logic                      clk_in,
	input  wire logic                      srst_in,
	// axi4-lite write address and data
	input  wire logic [7:0]                s_axi_awaddr_in,
	input  wire logic                      s_axi_awvalid_in,
	output logic                           s_axi_awready_out,
	input  wire logic [31:0]               s_axi_wdata_in,
	input  wire logic [3:0]                s_axi_wstrb_in,
	input  wire logic                      s_axi_wvalid_in,
	output logic                           s_axi_wready_out,
	output gosm_pkg::gosm_resp_t           s_axi_bresp_out,
	output logic                           s_axi_bvalid_out,
	input  wire logic                      s_axi_bready_in,
	// axi4-lite read
	input  wire logic [7:0]                s_axi_araddr_in,
	input  wire logic                      s_axi_arvalid_in,
	output logic                           s_axi_arready_out,
	output logic [31:0]                    s_axi_rdata_out,
	output gosm_pkg::gosm_resp_t           s_axi_rresp_out,
	output logic                           s_axi_rvalid_out,
	input  wire logic                      s_axi_rready_in,
	// receive port status, from other clock domains
	input  wire logic [NUM_RX*4-1:0]       rx_remote_pin_in,
	input  wire logic [NUM_RX-1:0]         rx_lock_in,
	input  wire logic [NUM_RX-1:0]         rx_pass_in,
	input  wire logic [NUM_RX-1:0]         rx_frame_valid_in,
	input  wire logic [NUM_RX-1:0]         rx_line_valid_in,
	input  wire logic [NUM_RX-1:0]         rx_enabled_in,
	// device status
	input  wire logic                      frame_sync_pulse_in,
	// transmit port status
	input  wire logic [NUM_TX*NUM_RX-1:0]  tx_rx_assign_in,
	input  wire logic [NUM_TX-1:0]         tx_frame_active_in,
	input  wire logic [NUM_TX-1:0]         tx_line_active_in,
	input  wire logic [NUM_TX-1:0]         tx_synced_in,
	input  wire logic [NUM_TX-1:0]         tx_irq_in,
	// general pin 5 drive
	output logic                           general_pin_5_out,
	output logic                           general_pin_5_oe_out
);
	import gosm_pkg::*;

	localparam int NSYNC = NUM_RX * 9 + 1 + NUM_TX * 4;

	// ==========================================================
	// input synchronisers
	// ==========================================================
	// all status inputs but tx_rx_assign_in come from other domains; a change counts
	// once stages 2 and 3 agree, otherwise the old value holds
	logic [NSYNC-1:0] raw_w;
	logic [NSYNC-1:0] s1_r, s2_r, s3_r, flt_r;
	logic [NSYNC-1:0] s1_nxt, s2_nxt, s3_nxt, flt_nxt;

	assign raw_w = {rx_remote_pin_in, rx_lock_in, rx_pass_in,
		rx_frame_valid_in, rx_line_valid_in, rx_enabled_in,
		frame_sync_pulse_in, tx_frame_active_in, tx_line_active_in,
		tx_synced_in, tx_irq_in};

	always_comb begin
		s1_nxt = raw_w;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
		flt_nxt = flt_r;
		for (int i = 0; i < NSYNC; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				flt_nxt[i] = s3_r[i];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			s1_r <= '0;
			s2_r <= '0;
			s3_r <= '0;
			flt_r <= '0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
			flt_r <= flt_nxt;
		end
	end

	logic [NUM_RX*4-1:0] rpin_w;
	logic [NUM_RX-1:0]   lock_w, pass_w, fv_w, lv_w, ena_w;
	logic                fsync_w;
	logic [NUM_TX-1:0]   tfv_w, tlv_w, tsyn_w, tirq_w;

	assign {rpin_w, lock_w, pass_w, fv_w, lv_w, ena_w, fsync_w,
		tfv_w, tlv_w, tsyn_w, tirq_w} = flt_r;

	// ==========================================================
	// control register and axi4-lite slave
	// ==========================================================
	logic [7:0]  ctrl_r, ctrl_nxt;
	logic        aw_got_r, w_got_r, bvalid_r, rvalid_r;
	logic        aw_got_nxt, w_got_nxt, bvalid_nxt, rvalid_nxt;
	logic [7:0]  awaddr_r, awaddr_nxt;
	logic [7:0]  wdata_r, wdata_nxt;
	logic        wstrb0_r, wstrb0_nxt;
	gosm_resp_t  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;

	// one write at a time: address and data are refused while a
	// response is pending, which keeps the slave state trivial
	assign s_axi_awready_out = !aw_got_r && !bvalid_r;
	assign s_axi_wready_out  = !w_got_r && !bvalid_r;
	assign s_axi_arready_out = !rvalid_r;
	assign s_axi_bvalid_out  = bvalid_r;
	assign s_axi_bresp_out   = bresp_r;
	assign s_axi_rvalid_out  = rvalid_r;
	assign s_axi_rresp_out   = rresp_r;
	assign s_axi_rdata_out   = rdata_r;

	always_comb begin
		ctrl_nxt = ctrl_r;
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb0_nxt = wstrb0_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			aw_got_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_got_nxt = 1'b1;
			wdata_nxt = s_axi_wdata_in[7:0];
			wstrb0_nxt = s_axi_wstrb_in[0];
		end
		if (aw_got_r && w_got_r) begin
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			if (awaddr_r[7:2] == 6'(`GOSM_CTRL_IDX)) begin
				bresp_nxt = GOSM_RESP_OKAY;
				// [R18] all fields writable
				if (wstrb0_r) begin
					ctrl_nxt = wdata_r;
				end
			end else begin
				bresp_nxt = GOSM_RESP_SLVERR;
			end
		end else if (bvalid_r && s_axi_bready_in) begin
			bvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid_in && s_axi_arready_out) begin
			rvalid_nxt = 1'b1;
			if (s_axi_araddr_in[7:2] == 6'(`GOSM_CTRL_IDX)) begin
				rresp_nxt = GOSM_RESP_OKAY;
				rdata_nxt = {24'h000000, ctrl_r};
			end else begin
				rresp_nxt = GOSM_RESP_SLVERR;
				rdata_nxt = 32'h00000000;
			end
		end else if (rvalid_r && s_axi_rready_in) begin
			rvalid_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			// [R18] reset to zero
			ctrl_r <= `GOSM_CTRL_RESET;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 8'h00;
			wstrb0_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= GOSM_RESP_OKAY;
			rvalid_r <= 1'b0;
			rresp_r <= GOSM_RESP_OKAY;
			rdata_r <= 32'h00000000;
		end else begin
			ctrl_r <= ctrl_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb0_r <= wstrb0_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ==========================================================
	// output source mux
	// ==========================================================
	logic [2:0] sel_w, src_w;
	logic       lvl_w, en_w;

	assign sel_w = ctrl_r[`GOSM_SEL_HI:`GOSM_SEL_LO];
	assign src_w = ctrl_r[`GOSM_SRC_HI:`GOSM_SRC_LO];
	assign lvl_w = ctrl_r[`GOSM_VAL_BIT];
	assign en_w  = ctrl_r[`GOSM_EN_BIT];

	// per transmit port: AND and OR of pass over assigned ports
	logic [NUM_TX-1:0] tx_and_w, tx_or_w;
	genvar g;
	generate
		for (g = 0; g < NUM_TX; g++) begin : g_tx
			logic [NUM_RX-1:0] asg_w;
			assign asg_w = tx_rx_assign_in[g*NUM_RX +: NUM_RX];
			// [R12] assigned pass
			assign tx_and_w[g] = &(pass_w | ~asg_w);
			assign tx_or_w[g]  = |(pass_w & asg_w);
		end
	endgenerate

	logic pin_nxt, pin_r, oe_r;
	logic [1:0] rxi_w;
	logic       txi_w;

	assign rxi_w = src_w[1:0];
	// [R11] low bit picks transmit port
	assign txi_w = src_w[0];

	// [R02] group then selection
	always_comb begin
		pin_nxt = 1'b0;
		// [R01] source decode
		unique case (src_w)
			3'h0, 3'h1, 3'h2, 3'h3: begin
				unique case (sel_w)
					// [R03] remote pins
					3'h0, 3'h1, 3'h2, 3'h3: begin
						pin_nxt = rpin_w[rxi_w*4 + sel_w[1:0]];
					end
					// [R04] lock and pass
					3'h4: pin_nxt = lock_w[rxi_w];
					3'h5: pin_nxt = pass_w[rxi_w];
					// [R05] frame and line valid
					3'h6: pin_nxt = fv_w[rxi_w];
					3'h7: pin_nxt = lv_w[rxi_w];
				endcase
			end
			3'h4: begin
				unique case (sel_w)
					// [R06] [R16] register level
					3'h0: pin_nxt = lvl_w;
					// [R07] any lock
					3'h1: pin_nxt = |(lock_w & ena_w);
					// [R08] all lock
					3'h2: pin_nxt = &(lock_w | ~ena_w);
					// [R09] all pass
					3'h3: pin_nxt = &(pass_w | ~ena_w);
					// [R10] frame sync, rest low
					3'h4: pin_nxt = fsync_w;
					3'h5, 3'h6, 3'h7: pin_nxt = 1'b0;
				endcase
			end
			3'h5: pin_nxt = 1'b0;
			3'h6, 3'h7: begin
				unique case (sel_w)
					3'h0: pin_nxt = tx_and_w[txi_w];
					3'h1: pin_nxt = tx_or_w[txi_w];
					// [R13] frame and line in progress
					3'h2: pin_nxt = tfv_w[txi_w];
					3'h3: pin_nxt = tlv_w[txi_w];
					// [R14] merged data synchronized
					3'h4: pin_nxt = tsyn_w[txi_w];
					// [R15] interrupt, rest low
					3'h5: pin_nxt = tirq_w[txi_w];
					3'h6, 3'h7: pin_nxt = 1'b0;
				endcase
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			pin_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			pin_r <= pin_nxt;
			// [R17] drive enable
			oe_r <= en_w;
		end
	end

	// pin level is forced low while released so the pad sees no glitch
	assign general_pin_5_out    = pin_r & oe_r;
	assign general_pin_5_oe_out = oe_r;

endmodule

// ===== design/gosm_pkg.sv
package gosm_pkg;
	typedef enum logic [1:0] {
		GOSM_RESP_OKAY   = 2'b00,
		GOSM_RESP_SLVERR = 2'b10
	} gosm_resp_t;
endpackage

// ===== sim/gosm_pin5_props.sv
`timescale 1ns/10ps
module gosm_pin5_props (
	// clock and reset
	input wire logic                 clk_in,
	input wire logic                 srst_in,
	// bus handshakes
	input wire logic                 s_axi_awvalid_in,
	input wire logic                 s_axi_awready_out,
	input wire logic                 s_axi_wvalid_in,
	input wire logic                 s_axi_wready_out,
	input wire gosm_pkg::gosm_resp_t s_axi_bresp_out,
	input wire logic                 s_axi_bvalid_out,
	input wire logic                 s_axi_bready_in,
	input wire logic [7:0]           s_axi_araddr_in,
	input wire logic                 s_axi_arvalid_in,
	input wire logic                 s_axi_arready_out,
	input wire logic [31:0]          s_axi_rdata_out,
	input wire gosm_pkg::gosm_resp_t s_axi_rresp_out,
	input wire logic                 s_axi_rvalid_out,
	input wire logic                 s_axi_rready_in,
	// pin
	input wire logic                 general_pin_5_out,
	input wire logic                 general_pin_5_oe_out
);
	import gosm_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (srst_in);
	// =========================================
	// pin driver
	property p_oe_off;
		!general_pin_5_oe_out |-> !general_pin_5_out;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("pin high while released");
	// =========================================
	// register access
	property p_b_hold;
		s_axi_bvalid_out && !s_axi_bready_in |=>
			s_axi_bvalid_out && $stable(s_axi_bresp_out);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	// address and data taken together: answer two edges later
	property p_b_ans;
		s_axi_awvalid_in && s_axi_awready_out &&
			s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out;
	endproperty
	a_b_ans: assert property (p_b_ans) else $error("write answer late");
	property p_r_hold;
		s_axi_rvalid_out && !s_axi_rready_in |=>
			s_axi_rvalid_out && $stable(s_axi_rdata_out);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_ar_ans;
		s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out;
	endproperty
	a_ar_ans: assert property (p_ar_ans) else $error("read answer late");
	property p_rd_ok;
		s_axi_arvalid_in && s_axi_arready_out &&
			s_axi_araddr_in[7:2] == 6'h15 |=>
			s_axi_rresp_out == GOSM_RESP_OKAY && s_axi_rdata_out[31:8] == 24'h0;
	endproperty
	a_rd_ok: assert property (p_rd_ok) else $error("bad control read");
	property p_rd_bad;
		s_axi_arvalid_in && s_axi_arready_out &&
			s_axi_araddr_in[7:2] != 6'h15 |=>
			s_axi_rresp_out == GOSM_RESP_SLVERR && s_axi_rdata_out == 32'h0;
	endproperty
	a_rd_bad: assert property (p_rd_bad) else $error("bad unmapped read");
	property p_w_block;
		s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
	endproperty
	a_w_block: assert property (p_w_block) else $error("write taken early");
	property p_ar_block;
		s_axi_rvalid_out |-> !s_axi_arready_out;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken early");
endmodule

bind gosm_pin5 gosm_pin5_props u_props (
	.clk_in               (clk_in),
	.srst_in              (srst_in),
	.s_axi_awvalid_in     (s_axi_awvalid_in),
	.s_axi_awready_out    (s_axi_awready_out),
	.s_axi_wvalid_in      (s_axi_wvalid_in),
	.s_axi_wready_out     (s_axi_wready_out),
	.s_axi_bresp_out      (s_axi_bresp_out),
	.s_axi_bvalid_out     (s_axi_bvalid_out),
	.s_axi_bready_in      (s_axi_bready_in),
	.s_axi_araddr_in      (s_axi_araddr_in),
	.s_axi_arvalid_in     (s_axi_arvalid_in),
	.s_axi_arready_out    (s_axi_arready_out),
	.s_axi_rdata_out      (s_axi_rdata_out),
	.s_axi_rresp_out      (s_axi_rresp_out),
	.s_axi_rvalid_out     (s_axi_rvalid_out),
	.s_axi_rready_in      (s_axi_rready_in),
	.general_pin_5_out    (general_pin_5_out),
	.general_pin_5_oe_out (general_pin_5_oe_out)
);

// ===== sim/testbench.sv
`timescale 1ns/10ps
module testbench;
	import gosm_pkg::*;
	logic        clk_in = 0, srst_in = 1;
	logic [7:0]  s_axi_awaddr_in = 0, s_axi_araddr_in = 0;
	logic        s_axi_awvalid_in = 0, s_axi_wvalid_in = 0;
	logic        s_axi_bready_in = 0, s_axi_arvalid_in = 0;
	logic        s_axi_rready_in = 0;
	logic [31:0] s_axi_wdata_in = 0, s_axi_rdata_out;
	logic [3:0]  s_axi_wstrb_in = 0;
	logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
	logic        s_axi_arready_out, s_axi_rvalid_out;
	logic        general_pin_5_out, general_pin_5_oe_out;
	gosm_resp_t  s_axi_bresp_out, s_axi_rresp_out;
	logic [15:0] rx_remote_pin_in;
	logic [3:0]  rx_lock_in, rx_pass_in, rx_frame_valid_in;
	logic [3:0]  rx_line_valid_in, rx_enabled_in;
	logic        frame_sync_pulse_in;
	logic [7:0]  tx_rx_assign_in;
	logic [1:0]  tx_frame_active_in, tx_line_active_in, tx_synced_in, tx_irq_in;
	logic [52:0] stim = 0;
	int          n_fail = 0, samples_checked = 0;
	// status inputs packed so a whole pattern changes in one step
	assign {tx_irq_in, tx_synced_in, tx_line_active_in, tx_frame_active_in,
		tx_rx_assign_in, frame_sync_pulse_in, rx_enabled_in,
		rx_line_valid_in, rx_frame_valid_in, rx_pass_in, rx_lock_in,
		rx_remote_pin_in} = stim;
	gosm_pin5 u_dut (.*);
	initial forever #10 clk_in = ~clk_in;
	initial begin
		#400000;
		n_fail++;
		stop_test();
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// ready is looked at on the falling edge, acted on at the next rise
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] st, output logic [1:0] r);
		logic ta, tw;
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= d;
		s_axi_wstrb_in <= st;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		@(negedge clk_in);
		while (s_axi_awvalid_in || s_axi_wvalid_in) begin
			ta = s_axi_awready_out;
			tw = s_axi_wready_out;
			@(posedge clk_in);
			if (ta) s_axi_awvalid_in <= 1'b0;
			if (tw) s_axi_wvalid_in <= 1'b0;
			@(negedge clk_in);
		end
		while (!s_axi_bvalid_out) @(negedge clk_in);
		r = s_axi_bresp_out;
		@(posedge clk_in);
		s_axi_bready_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		@(negedge clk_in);
		while (!s_axi_arready_out) @(negedge clk_in);
		@(posedge clk_in);
		s_axi_arvalid_in <= 1'b0;
		@(negedge clk_in);
		while (!s_axi_rvalid_out) @(negedge clk_in);
		d = s_axi_rdata_out;
		r = s_axi_rresp_out;
		@(posedge clk_in);
		s_axi_rready_in <= 1'b0;
	endtask
	function automatic logic expf(input logic [52:0] s,
		input logic [2:0] src, sel, input logic val);
		logic [3:0] e, l, p, a;
		int t;
		e = s[35:32];
		l = s[19:16];
		p = s[23:20];
		t = src[0];
		a = t ? s[44:41] : s[40:37];
		expf = 1'b0;
		if (!src[2])
			expf = sel[2] ? s[16 + 4 * sel[1:0] + src[1:0]]
				: s[{src[1:0], sel[1:0]}];
		else if (!src[1])
			case (sel)
				3'h0: expf = src[0] ? 1'b0 : val;
				3'h1: expf = |(l & e) & !src[0];
				3'h2: expf = &(l | ~e) & !src[0];
				3'h3: expf = &(p | ~e) & !src[0];
				3'h4: expf = s[36] & !src[0];
				default: expf = 1'b0;
			endcase
		else
			case (sel)
				3'h0: expf = &(p | ~a);
				3'h1: expf = |(p & a);
				3'h2, 3'h3, 3'h4, 3'h5: expf = s[45 + 2 * (sel - 2) + t];
				default: expf = 1'b0;
			endcase
	endfunction
	initial begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  c;
		logic [52:0] pat [3];
		pat = '{53'h1a5c3e9617b4d2, ~53'h1a5c3e9617b4d2, 53'h0};
		repeat (10) @(posedge clk_in);
		srst_in <= 1'b0;
		@(posedge clk_in);
		rd(8'h54, d, r);
		chk("reset value", d, 32'h0);
		wr(8'h58, 32'hff, 4'hf, r);
		chk("unmapped bresp", 32'(r), 32'h2);
		rd(8'h58, d, r);
		chk("unmapped rresp", 32'(r), 32'h2);
		$display("test bus done");
		for (int p = 0; p < 3; p++)
			for (int i = 0; i < 128; i++) begin
				c = 8'(i * 2 + 1);
				stim <= pat[p];
				wr(8'h54, {24'h0, c}, 4'h1, r);
				rd(8'h54, d, r);
				chk("control", d, {24'h0, c});
				repeat (8) @(posedge clk_in);
				@(negedge clk_in);
				chk("pin", 32'(general_pin_5_out),
					32'(expf(pat[p], c[4:2], c[7:5], c[1])));
				chk("enable", 32'(general_pin_5_oe_out), 32'h1);
			end
		$display("test mux done");
		wr(8'h54, 32'h12, 4'h1, r);
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		chk("released pin", 32'(general_pin_5_out), 32'h0);
		chk("released oe", 32'(general_pin_5_oe_out), 32'h0);
		wr(8'h54, 32'hff, 4'h0, r);
		chk("masked bresp", 32'(r), 32'h0);
		rd(8'h54, d, r);
		chk("masked write", d, 32'h12);
		$display("test enable done");
		// mid-run reset with the pin driven must clear everything
		wr(8'h54, 32'h13, 4'h1, r);
		srst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		srst_in <= 1'b0;
		@(posedge clk_in);
		@(negedge clk_in);
		chk("reset oe", 32'(general_pin_5_oe_out), 32'h0);
		chk("reset pin", 32'(general_pin_5_out), 32'h0);
		@(posedge clk_in);
		rd(8'h54, d, r);
		chk("reset again", d, 32'h0);
		$display("test reset done");
		stop_test();
	end
endmodule
